// file: rtl/gpfs_top.sv
// Top of the per-pin function select block with its AXI4-Lite register slave
// What this block does
// R1 - Isolated analog input reaches pad only when digital enable clear and analog mode set.
// R2 - Direct analog inputs reach pad whenever digital enable is clear.
// R3 - Alternate peripheral uses pad only with select and enable set; code picks it.
// R4 - Every pin has its own select, enable and code; no grouping.
// R5 - Pads reset to tri-stated GPIO with all controls and codes zero, except listed pins.
// R6 - Any reset restores every pin's selection, enables, pulls and codes to defaults.
// R7 - Port A bits 0-5 and B bits 2-3 reset as alternate, enabled, code 1.
// R8 - Port C bits 0-3 reset as alternate, enabled, pulled up, code 3.
// R9 - Without alternate select, port data and direction drive the pad; else peripheral.
`timescale 1ns/1ps
module gpfs_top (
    input  wire logic                                                  clk,
    input  wire logic                                                  reset,
    input  wire logic                                                  ce,
    input  wire gpfs_pkg::gpfs_axi_req_type                            axi_req,
    output gpfs_pkg::gpfs_axi_rsp_type                                 axi_rsp,
    input  wire logic [gpfs_pkg::PIN_COUNT-1:0]                        pad_in,
    input  wire logic [gpfs_pkg::PIN_COUNT-1:0][gpfs_pkg::CODE_COUNT-1:0] periph_out,
    input  wire logic [gpfs_pkg::PIN_COUNT-1:0][gpfs_pkg::CODE_COUNT-1:0] periph_oe,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        pad_out,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        pad_oe,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        pad_pu,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        pad_pd,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        pad_ie,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        isolated_analog_inputs,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        analog_direct_connect,
    output logic      [gpfs_pkg::PIN_COUNT-1:0]                        periph_in,
    output logic      [gpfs_pkg::PIN_COUNT-1:0][gpfs_pkg::CODE_WIDTH-1:0] pin_mux_code_field
);
    import gpfs_pkg::*;

    // Per-port configuration registers
    logic [PORT_COUNT-1:0][7:0]  data_r;
    logic [PORT_COUNT-1:0][7:0]  dir_r;
    logic [PORT_COUNT-1:0][7:0]  alt_function_select_reg;
    logic [PORT_COUNT-1:0][7:0]  digital_enable_reg;
    logic [PORT_COUNT-1:0][7:0]  pull_down_reg;
    logic [PORT_COUNT-1:0][7:0]  pull_up_reg;
    logic [PORT_COUNT-1:0][7:0]  analog_select_reg;
    logic [PORT_COUNT-1:0][31:0] port_control_reg;
    logic [PIN_COUNT-1:0]        pad_in_r;

    // Bus slave state
    logic                  awready_r;
    logic                  wready_r;
    logic                  aw_have_r;
    logic                  w_have_r;
    logic [ADDR_WIDTH-1:0] awaddr_r;
    logic [31:0]           wdata_r;
    logic [3:0]            wstrb_r;
    logic                  bvalid_r;
    logic [1:0]            bresp_r;
    logic                  arready_r;
    logic                  rvalid_r;
    logic [31:0]           rdata_r;
    logic [1:0]            rresp_r;

    assign axi_rsp.awready = awready_r;
    assign axi_rsp.wready  = wready_r;
    assign axi_rsp.bvalid  = bvalid_r;
    assign axi_rsp.bresp   = bresp_r;
    assign axi_rsp.arready = arready_r;
    assign axi_rsp.rvalid  = rvalid_r;
    assign axi_rsp.rdata   = rdata_r;
    assign axi_rsp.rresp   = rresp_r;

    // Write channel decode
    wire aw_fire = axi_req.awvalid & awready_r;
    wire w_fire  = axi_req.wvalid & wready_r;
    wire aw_got  = aw_have_r | aw_fire;
    wire w_got   = w_have_r | w_fire;
    wire [ADDR_WIDTH-1:0] wr_addr = aw_have_r ? awaddr_r : axi_req.awaddr;
    wire [31:0]           wr_data = w_have_r ? wdata_r : axi_req.wdata;
    wire [3:0]            wr_strb = w_have_r ? wstrb_r : axi_req.wstrb;
    wire wr_fire = aw_got & w_got & ~bvalid_r;
    wire [2:0] wr_port = wr_addr[ADDR_WIDTH-1:PORT_LSB];
    wire [3:0] wr_idx  = wr_addr[PORT_LSB-1:IDX_LSB];
    wire wr_ok = (wr_port <= PORT_LAST) & (wr_idx <= REG_LAST_IDX);

    // Read channel decode
    wire ar_fire = axi_req.arvalid & arready_r;
    wire [2:0] rd_port = axi_req.araddr[ADDR_WIDTH-1:PORT_LSB];
    wire [3:0] rd_idx  = axi_req.araddr[PORT_LSB-1:IDX_LSB];
    wire rd_ok = (rd_port <= PORT_LAST) & (rd_idx <= REG_LAST_IDX);
    wire [2:0] rd_p = rd_ok ? rd_port : 3'h0;
    wire [7:0] rd_pin_val;
    wire [31:0] rd_word =
        ~rd_ok                   ? 32'h0000_0000 :
        rd_idx == REG_DATA_IDX   ? {24'h00_0000, rd_pin_val} :
        rd_idx == REG_DIR_IDX    ? {24'h00_0000, dir_r[rd_p]} :
        rd_idx == REG_AFSEL_IDX  ? {24'h00_0000, alt_function_select_reg[rd_p]} :
        rd_idx == REG_DEN_IDX    ? {24'h00_0000, digital_enable_reg[rd_p]} :
        rd_idx == REG_PDR_IDX    ? {24'h00_0000, pull_down_reg[rd_p]} :
        rd_idx == REG_PUR_IDX    ? {24'h00_0000, pull_up_reg[rd_p]} :
        rd_idx == REG_ANALOG_MODE_SELECT_BIT_IDX  ? {24'h00_0000, analog_select_reg[rd_p]} :
                                   port_control_reg[rd_p];

    // Data reads show driven value on outputs, pad level on inputs
    assign rd_pin_val = (data_r[rd_p] & dir_r[rd_p])
                      | (pad_in_r[rd_p*PIN_PER_PORT +: PIN_PER_PORT] & ~dir_r[rd_p]);

    // Write address and data are taken independently
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else if (ce) begin
            aw_have_r <= aw_got & ~wr_fire;
            w_have_r  <= w_got & ~wr_fire;
            awready_r <= ~(aw_got & ~wr_fire);
            wready_r  <= ~(w_got & ~wr_fire);
            if (aw_fire) begin
                awaddr_r <= axi_req.awaddr;
            end
            if (w_fire) begin
                wdata_r <= axi_req.wdata;
                wstrb_r <= axi_req.wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (axi_req.bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read address and response
    always_ff @(posedge clk) begin
        if (reset) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_word;
                rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_r & axi_req.rready) begin
                arready_r <= 1'b1;
                rvalid_r  <= 1'b0;
            end
        end
    end

    // Per-port register file with reset defaults
    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        wire hit = wr_fire & wr_ok & (wr_port == 3'(p));
        wire b0  = hit & wr_strb[0];

        always_ff @(posedge clk) begin
            if (reset) begin                                             // R6
                data_r[p]                  <= ZERO8_RST[p];
                dir_r[p]                   <= ZERO8_RST[p];
                alt_function_select_reg[p] <= AFSEL_RST[p];              // R5 R7 R8
                digital_enable_reg[p]      <= DEN_RST[p];                // R5 R7 R8
                pull_down_reg[p]           <= PDR_RST[p];                // R5
                pull_up_reg[p]             <= PUR_RST[p];                // R5 R8
                analog_select_reg[p]       <= ZERO8_RST[p];
                port_control_reg[p]        <= PCTL_RST[p];               // R5 R7 R8
            end else if (ce) begin
                if (b0 && wr_idx == REG_DATA_IDX) begin
                    data_r[p] <= wr_data[7:0];
                end
                if (b0 && wr_idx == REG_DIR_IDX) begin
                    dir_r[p] <= wr_data[7:0];
                end
                if (b0 && wr_idx == REG_AFSEL_IDX) begin
                    alt_function_select_reg[p] <= wr_data[7:0];
                end
                if (b0 && wr_idx == REG_DEN_IDX) begin
                    digital_enable_reg[p] <= wr_data[7:0];
                end
                if (b0 && wr_idx == REG_PDR_IDX) begin
                    pull_down_reg[p] <= wr_data[7:0];
                end
                if (b0 && wr_idx == REG_PUR_IDX) begin
                    pull_up_reg[p] <= wr_data[7:0];
                end
                if (b0 && wr_idx == REG_ANALOG_MODE_SELECT_BIT_IDX) begin
                    analog_select_reg[p] <= wr_data[7:0];
                end
                for (int b = 0; b < 4; b++) begin
                    if (hit && wr_strb[b] && wr_idx == REG_PCTL_IDX) begin
                        port_control_reg[p][b*8 +: 8] <= wr_data[b*8 +: 8];
                    end
                end
            end
        end
    end

    // One lane per pad, each with its own controls
    gpfs_pad_drive_type [PIN_COUNT-1:0] lane_w;

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_lane
        localparam int P = i / PIN_PER_PORT;
        localparam int B = i % PIN_PER_PORT;
        gpfs_pin_cfg_type cfg_w;

        assign cfg_w.afsel = alt_function_select_reg[P][B];             // R4
        assign cfg_w.digital_enable_bit   = digital_enable_reg[P][B];
        assign cfg_w.pdr   = pull_down_reg[P][B];
        assign cfg_w.pur   = pull_up_reg[P][B];
        assign cfg_w.analog_mode_select_bit = analog_select_reg[P][B];
        assign cfg_w.code  = port_control_reg[P][B*CODE_WIDTH +: CODE_WIDTH];

        gpfs_pin_lane u_lane (
            .cfg        (cfg_w),
            .gpio_data  (data_r[P][B]),
            .gpio_dir   (dir_r[P][B]),
            .periph_out (periph_out[i]),
            .periph_oe  (periph_oe[i]),
            .pad_in     (pad_in[i]),
            .lane       (lane_w[i])
        );

        // Registered pad and peripheral outputs
        always_ff @(posedge clk) begin
            if (reset) begin
                pad_out[i]                <= 1'b0;
                pad_oe[i]                 <= 1'b0;
                pad_pu[i]                 <= 1'b0;
                pad_pd[i]                 <= 1'b0;
                pad_ie[i]                 <= 1'b0;
                isolated_analog_inputs[i] <= 1'b0;
                analog_direct_connect[i]  <= 1'b0;
                periph_in[i]              <= 1'b0;
                pin_mux_code_field[i]     <= 4'h0;
                pad_in_r[i]               <= 1'b0;
            end else if (ce) begin
                pad_out[i]                <= lane_w[i].out;             // R9
                pad_oe[i]                 <= lane_w[i].oe;              // R9
                pad_pu[i]                 <= lane_w[i].pu;
                pad_pd[i]                 <= lane_w[i].pd;
                pad_ie[i]                 <= lane_w[i].ie;
                isolated_analog_inputs[i] <= lane_w[i].iso_conn;        // R1
                analog_direct_connect[i]  <= lane_w[i].direct_conn;     // R2
                periph_in[i]              <= lane_w[i].periph_in;       // R3
                pin_mux_code_field[i]     <= cfg_w.code;                // R3
                pad_in_r[i]               <= pad_in[i];
            end
        end
    end

endmodule

// file: rtl/gpfs_pkg.sv
// Package for the per-pin function select block: map, reset values, carrier types
package gpfs_pkg;

    localparam int PORT_COUNT  = 7;
    localparam int PIN_PER_PORT = 8;
    localparam int PIN_COUNT   = PORT_COUNT * PIN_PER_PORT;
    localparam int CODE_WIDTH  = 4;
    localparam int CODE_COUNT  = 16;
    localparam int ADDR_WIDTH  = 9;

    // Register offsets inside one port window
    localparam logic [3:0] REG_DATA_IDX  = 4'h0;
    localparam logic [3:0] REG_DIR_IDX   = 4'h1;
    localparam logic [3:0] REG_AFSEL_IDX = 4'h2;
    localparam logic [3:0] REG_DEN_IDX   = 4'h3;
    localparam logic [3:0] REG_PDR_IDX   = 4'h4;
    localparam logic [3:0] REG_PUR_IDX   = 4'h5;
    localparam logic [3:0] REG_ANALOG_MODE_SELECT_BIT_IDX = 4'h6;
    localparam logic [3:0] REG_PCTL_IDX  = 4'h7;
    localparam logic [3:0] REG_LAST_IDX  = 4'h7;

    // Address fields: port window of 0x40 bytes, word index inside it
    localparam int PORT_LSB = 6;
    localparam int IDX_LSB  = 2;
    localparam logic [2:0] PORT_LAST = 3'h6;

    // Reset values, port A in the lowest slice
    localparam logic [6:0][7:0]  AFSEL_RST = {8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h0C, 8'h3F};
    localparam logic [6:0][7:0]  DEN_RST   = {8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h0C, 8'h3F};
    localparam logic [6:0][7:0]  PDR_RST   = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [6:0][7:0]  PUR_RST   = {8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
    localparam logic [6:0][7:0]  ZERO8_RST = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [6:0][31:0] PCTL_RST  = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                              32'h0000_0000, 32'h0000_3333, 32'h0000_1100,
                                              32'h0011_1111};

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic                  awvalid;
        logic [ADDR_WIDTH-1:0] awaddr;
        logic                  wvalid;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bready;
        logic                  arvalid;
        logic [ADDR_WIDTH-1:0] araddr;
        logic                  rready;
    } gpfs_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } gpfs_axi_rsp_type;

    typedef struct packed {
        logic                  afsel;
        logic                  digital_enable_bit;
        logic                  pdr;
        logic                  pur;
        logic                  analog_mode_select_bit;
        logic [CODE_WIDTH-1:0] code;
    } gpfs_pin_cfg_type;

    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
        logic pd;
        logic ie;
        logic iso_conn;
        logic direct_conn;
        logic periph_in;
    } gpfs_pad_drive_type;

endpackage

// file: rtl/gpfs_pin_lane.sv
// One pad lane: selects GPIO, alternate peripheral or analog path
`timescale 1ns/1ps
module gpfs_pin_lane (
    input  wire gpfs_pkg::gpfs_pin_cfg_type          cfg,
    input  wire logic                                gpio_data,
    input  wire logic                                gpio_dir,
    input  wire logic [gpfs_pkg::CODE_COUNT-1:0]     periph_out,
    input  wire logic [gpfs_pkg::CODE_COUNT-1:0]     periph_oe,
    input  wire logic                                pad_in,
    output gpfs_pkg::gpfs_pad_drive_type             lane
);
    import gpfs_pkg::*;

    wire alt_active = cfg.afsel & cfg.digital_enable_bit;                               // R3
    wire sel_out    = cfg.afsel ? periph_out[cfg.code] : gpio_data;      // R9
    wire sel_oe     = cfg.afsel ? periph_oe[cfg.code] : gpio_dir;        // R9

    assign lane.out         = sel_out;
    assign lane.oe          = sel_oe & cfg.digital_enable_bit;                          // R3
    assign lane.pu          = cfg.pur;
    assign lane.pd          = cfg.pdr;
    assign lane.ie          = cfg.digital_enable_bit;
    assign lane.iso_conn    = ~cfg.digital_enable_bit & cfg.analog_mode_select_bit;                      // R1
    assign lane.direct_conn = ~cfg.digital_enable_bit;                                  // R2
    assign lane.periph_in   = alt_active & pad_in;                       // R3
endmodule

// file: verification/gpfs_periph_model.sv
// Peripheral side model: per pin and per code output value and enable
`timescale 1ns/1ps
module gpfs_periph_model (
    input  wire logic [31:0]                                              seed,
    output logic      [gpfs_pkg::PIN_COUNT-1:0][gpfs_pkg::CODE_COUNT-1:0] periph_out,
    output logic      [gpfs_pkg::PIN_COUNT-1:0][gpfs_pkg::CODE_COUNT-1:0] periph_oe
);
    import gpfs_pkg::*;
    // Values differ per pin and code, held until the seed moves
    always_comb begin
        for (int n = 0; n < PIN_COUNT; n++) begin
            periph_out[n] = seed[15:0] ^ 16'(n * 16'h9E37);
            periph_oe[n]  = seed[31:16] ^ 16'(n * 16'h7F4B);
        end
    end
endmodule

// file: verification/gpfs_properties.sv
// Checker of pin selection outputs and register bus timing
`timescale 1ns/1ps
module gpfs_properties (
    input wire logic                                                  clk,
    input wire logic                                                  reset,
    input wire logic                                                  ce,
    input wire gpfs_pkg::gpfs_axi_req_type                            axi_req,
    input wire gpfs_pkg::gpfs_axi_rsp_type                            axi_rsp,
    input wire logic [gpfs_pkg::PIN_COUNT-1:0]                        pad_oe,
    input wire logic [gpfs_pkg::PIN_COUNT-1:0]                        pad_pu,
    input wire logic [gpfs_pkg::PIN_COUNT-1:0]                        pad_ie,
    input wire logic [gpfs_pkg::PIN_COUNT-1:0]                        isolated_analog_inputs,
    input wire logic [gpfs_pkg::PIN_COUNT-1:0]                        analog_direct_connect,
    input wire logic [gpfs_pkg::PIN_COUNT-1:0]                        periph_in,
    input wire logic [gpfs_pkg::PIN_COUNT-1:0][gpfs_pkg::CODE_WIDTH-1:0] pin_mux_code_field
);
    import gpfs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_ar_taken;
        axi_req.arvalid && axi_rsp.arready && ce;
    endsequence
    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready && ce
            && !axi_rsp.bvalid;
    endsequence
    sequence s_release;
        reset ##1 (!reset && ce);
    endsequence
    a_iso_needs_off: assert property ((isolated_analog_inputs & pad_ie) == '0)
        else $error("isolated analog path with digital enable set");
    a_direct_when_off: assert property (!$past(reset) |-> analog_direct_connect == ~pad_ie)
        else $error("direct analog path not equal to inverted digital enable");
    a_periph_gated: assert property ((periph_in & ~pad_ie) == '0)
        else $error("peripheral input passed with digital enable clear");
    a_oe_needs_den: assert property ((pad_oe & ~pad_ie) == '0)
        else $error("pad driven with digital enable clear");
    a_reset_clears: assert property (disable iff (1'b0) reset |=> pad_oe == '0 && pad_pu == '0)
        else $error("pad outputs not cleared by reset");
    a_reset_default: assert property (disable iff (1'b0) s_release |=> pad_ie == DEN_RST
        && pad_pu == PUR_RST && pin_mux_code_field == PCTL_RST)
        else $error("pad defaults wrong after reset");
    a_read_answer: assert property (s_ar_taken |=> axi_rsp.rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_wr_taken |=> axi_rsp.bvalid)
        else $error("write answer late");
    a_b_holds: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped early");
endmodule
bind gpfs_top gpfs_properties u_props (.clk, .reset, .ce, .axi_req, .axi_rsp, .pad_oe, .pad_pu,
    .pad_ie, .isolated_analog_inputs, .analog_direct_connect, .periph_in, .pin_mux_code_field);

// file: verification/gpio_pin_function_select_test.sv
// Self-checking bench for the pin function select block
`timescale 1ns/1ps
module gpio_pin_function_select_test;
    import gpfs_pkg::*;
    logic                                 clk = 1'b0;
    logic                                 reset = 1'b1;
    logic                                 ce = 1'b1;
    gpfs_axi_req_type                     req = '0;
    gpfs_axi_rsp_type                     rsp;
    logic [PIN_COUNT-1:0]                 pad_in = '0;
    logic [PIN_COUNT-1:0]                 pad_out, pad_oe, pad_pu, pad_pd, pad_ie, iso, dir_an, p_in;
    logic [PIN_COUNT-1:0][CODE_COUNT-1:0] p_out, p_oe;
    logic [PIN_COUNT-1:0][CODE_WIDTH-1:0] code;
    logic [31:0]                          pseed = '0;
    logic [31:0]                          m [7][8];
    integer                               seed = 32'h1A39;
    int                                   miscompares = 0;
    int                                   n_compared = 0;
    always #4 clk = ~clk;
    gpfs_periph_model u_periph (.seed(pseed), .periph_out(p_out), .periph_oe(p_oe));
    gpfs_top u_dut (.clk(clk), .reset(reset), .ce(ce), .axi_req(req), .axi_rsp(rsp),
        .pad_in(pad_in), .periph_out(p_out), .periph_oe(p_oe), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_ie(pad_ie),
        .isolated_analog_inputs(iso), .analog_direct_connect(dir_an), .periph_in(p_in),
        .pin_mux_code_field(code));
    task automatic finish_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) aw = 1'b0;
            if (rsp.wready) w = 1'b0;
            req.awvalid <= aw;
            req.wvalid <= w;
        end while (aw || w);
        while (!rsp.bvalid) @(posedge clk);
        req.bready <= 1'b1;
        @(posedge clk);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        while (!rsp.rvalid) @(posedge clk);
        req.rready <= 1'b1;
        @(posedge clk);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    function automatic logic [31:0] rexp(int p, int i);
        logic [7:0] dr;
        dr = m[p][1][7:0];
        if (i == 0) begin
            return {24'h0, (m[p][0][7:0] & dr) | (pad_in[p*8 +: 8] & ~dr)};
        end
        return (i == 7) ? m[p][i] : {24'h0, m[p][i][7:0]};
    endfunction
    task automatic load_defaults();
        m = '{default: '{default: 32'h0}};
        m[0][2] = 32'h3F;
        m[0][3] = 32'h3F;
        m[0][7] = 32'h0011_1111;
        m[1][2] = 32'h0C;
        m[1][3] = 32'h0C;
        m[1][7] = 32'h0000_1100;
        m[2][2] = 32'h0F;
        m[2][3] = 32'h0F;
        m[2][5] = 32'h0F;
        m[2][7] = 32'h0000_3333;
    endtask
    task automatic check_pins();
        #1;
        for (int n = 0; n < PIN_COUNT; n++) begin
            int p, b;
            logic af, de, am, eo;
            logic [3:0] c;
            p = n / 8;
            b = n % 8;
            af = m[p][2][b];
            de = m[p][3][b];
            am = m[p][6][b];
            c = m[p][7][4*b +: 4];
            eo = de && (af ? p_oe[n][c] : m[p][1][b]);
            chk(pad_ie[n], de, "input enable");
            chk(iso[n], !de && am, "isolated path");
            chk(dir_an[n], !de, "direct path");
            chk(pad_oe[n], eo, "output enable");
            if (eo) chk(pad_out[n], af ? p_out[n][c] : m[p][0][b], "pad out");
            chk(p_in[n], af && de && pad_in[n], "periph in");
            chk(code[n], c, "code");
            chk({pad_pu[n], pad_pd[n]}, {m[p][5][b], m[p][4][b]}, "pulls");
        end
        @(posedge clk);
    endtask
    task automatic check_all();
        logic [31:0] d;
        logic [1:0]  r;
        for (int p = 0; p < 7; p++) begin
            // Data word last, after the pad sample has settled
            for (int i = 7; i >= 0; i--) begin
                axi_rd(9'(p * 64 + i * 4), d, r);
                chk(d, rexp(p, i), "readback");
                chk(r, RESP_OKAY, "read resp");
            end
        end
        check_pins();
    endtask
    initial begin
        #500_000;
        miscompares++;
        finish_test();
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          p;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        load_defaults();
        check_all();
        axi_wr(9'h1C4, 32'hFFFF_FFFF, 4'hF, r);
        chk(r, RESP_SLVERR, "unmapped write");
        axi_rd(9'h020, d, r);
        chk(d, 32'h0, "unmapped read");
        chk(r, RESP_SLVERR, "unmapped resp");
        // Byte lanes: lane 0 off leaves select, lane 1 sets two codes
        axi_wr(9'h008, 32'h0000_00FF, 4'hE, r);
        chk(r, RESP_OKAY, "strobe write resp");
        axi_wr(9'h01C, 32'hFFFF_FFFF, 4'h2, r);
        chk(r, RESP_OKAY, "strobe write resp");
        m[0][7][15:8] = 8'hFF;
        check_all();
        repeat (30) begin
            p = {$random(seed)} % 7;
            pseed <= $random(seed);
            pad_in <= 56'({$random(seed), $random(seed)});
            for (int i = 0; i < 8; i++) begin
                d = $random(seed);
                axi_wr(9'(p * 64 + i * 4), d, 4'hF, r);
                m[p][i] = d;
                chk(r, RESP_OKAY, "write resp");
            end
            check_all();
        end
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        load_defaults();
        check_all();
        finish_test();
    end
endmodule
